// File: gmc_addr_mem.v
// station address table: 16 entries of low word and 24-bit high/mask word
// assumes writer and readers share pclk; read data is registered, one cycle late
module gmc_addr_mem (
	// clock
	input  wire        clk,
	// write port
	input  wire [3:0]  wr_idx,
	input  wire        we_lo,
	input  wire        we_hi,
	input  wire [31:0] wdata,
	// bus read port
	input  wire [3:0]  ra_idx,
	output reg  [55:0] ra_data,
	// filter read port
	input  wire [3:0]  rb_idx,
	output reg  [55:0] rb_data
);

	reg [31:0] lo_mem [0:15];
	reg [23:0] hi_mem [0:15];

	always @(posedge clk) begin
		if (we_lo) begin
			lo_mem[wr_idx] <= wdata;
		end
		if (we_hi) begin
			hi_mem[wr_idx] <= wdata[23:0];
		end
		ra_data <= {hi_mem[ra_idx], lo_mem[ra_idx]};
		rb_data <= {hi_mem[rb_idx], lo_mem[rb_idx]};
	end

endmodule

// File: gmc_link_model.sv
// far-side transmitter: sends the pause frame and reports completion
// assumes start is a one-cycle pulse; slow stretches the frame time
module gmc_link_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// pause handshake
	input  wire logic       pause_tx_start,
	output logic       pause_tx_done,
	// control and tally
	input  wire logic       slow,
	output logic [7:0] starts
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			pause_tx_done <= 1'b0;
			starts <= 8'h00;
		end else begin
			pause_tx_done <= (cnt == 1);
			if (pause_tx_start) begin
				starts <= starts + 8'h01;
				cnt <= slow ? 24 : 1;
			end else if (cnt != 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// File: gmc_regs.vh
// register map, field positions and timing counts of the mac control/status slice
// assumes a 32-bit apb bus with word-aligned registers and byte addresses
`ifndef GMC_REGS_VH
`define GMC_REGS_VH

// register byte offsets
`define GMC_OFS_RESET      12'h000
`define GMC_OFS_PAUSE_CTL  12'h004
`define GMC_OFS_PAUSE_DATA 12'h008
`define GMC_OFS_FLOW       12'h00C
`define GMC_OFS_RXMODE     12'h010
`define GMC_OFS_RXFIFO     12'h014
`define GMC_OFS_TXFIFO     12'h018
`define GMC_OFS_OFFLOAD    12'h01C
`define GMC_OFS_RXMAC_ENA  12'h020
`define GMC_OFS_LPI        12'h024
`define GMC_OFS_IRQ_STS    12'h028
`define GMC_OFS_IRQ_MSK    12'h02C
// station address table page: 0x100 + 8*n (low), 0x104 + 8*n (high/mask)
`define GMC_TAB_PAGE       4'h1
// table address fields: page select, unused half, entry index, high word, word alignment
`define GMC_TAB_SEL        11:8
`define GMC_TAB_GAP        7
`define GMC_TAB_IDX        6:3
`define GMC_TAB_HI_BIT     2
`define GMC_ALIGN          1:0

// mac_soft_reset bits
`define GMC_RST_RX_BIT     13
`define GMC_RST_TX_BIT     15
`define GMC_RST_ALL_BIT    31
// pause_send_control bit
`define GMC_PAUSE_REQ_BIT  31
// station_address_high_mask fields
`define GMC_ADR_HI         15:0
`define GMC_ADR_MASK       23:16
`define GMC_ADR_VLD_BIT    31
// receive_mode_register thresholds
`define GMC_RXM_AF         7:0
`define GMC_RXM_AE         15:8
`define GMC_RXM_RT         23:16
// rx_fifo_status flags
`define GMC_RXF_AF_BIT     31
`define GMC_RXF_AE_BIT     30
`define GMC_RXF_RT_BIT     29
`define GMC_RXF_LVL        7:0
// tx_fifo_status
`define GMC_TXF_FULL_BIT   31
`define GMC_TXF_LVL        7:0
// offload_control
`define GMC_ACC_RXOFF_BIT  2
// rx_mac_enable
`define GMC_RXENA_BIT      0

// interrupt status / mask bits
`define GMC_IRQ_W          6
`define GMC_IRQ_PAUSE      0
`define GMC_IRQ_RX_RST     1
`define GMC_IRQ_TX_RST     2
`define GMC_IRQ_ALL_RST    3
`define GMC_IRQ_ACCEPT     4
`define GMC_IRQ_REJECT     5

// reset values
`define GMC_RST_WORD       32'h0000_0000
`define GMC_RXMODE_RST     32'h0000_0000

// section reset counter width and start value; busy lasts start value plus one cycles
`define GMC_RST_CW         5
`define GMC_RST_LAST       5'h0F
// station table geometry
`define GMC_ENT_N          16
`define GMC_ENT_LAST       4'hF
`define GMC_SCAN_END       5'h10

`endif

// File: gmc_rst_timer.v
// fixed-length section reset sequencer: busy while the section is held in reset
// assumes start is a one-cycle request; starts while busy are ignored
`include "gmc_regs.vh"
module gmc_rst_timer (
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// control
	input  wire start,
	output reg  busy,
	output reg  done
);

	reg [`GMC_RST_CW-1:0] cnt_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= {`GMC_RST_CW{1'b0}};
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					busy  <= 1'b1;
					cnt_q <= `GMC_RST_LAST;
				end
			end else if (cnt_q == {`GMC_RST_CW{1'b0}}) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule

// File: gmc_sva.sv
// assertions on the apb and mac-side ports of gmc_top
// assumes one pclk domain with async active-low presetn
module gmc_sva (
	// apb
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// mac side
	input wire logic        pause_tx_start,
	input wire logic        rx_da_valid,
	input wire logic        rx_da_done,
	input wire logic        rx_path_reset,
	input wire logic        tx_path_reset,
	input wire logic        full_mac_reset,
	input wire logic        rx_checksum_offload_off,
	input wire logic        rx_header_pad
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_timing: assert property ($rose(psel && penable) |-> !pready ##1 pready ##1 !pready)
		else $error("pready not in second access cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_tx_full_zero: assert property (pready && !pwrite && paddr == 12'h018 |-> !prdata[31])
		else $error("tx full bit read as one");
	a_pause_cause: assert property (pause_tx_start |-> $past(psel && penable && pready && pwrite
		&& paddr == 12'h004 && pwdata[31]))
		else $error("pause start without request write");
	a_done_pulse: assert property (rx_da_done |=> !rx_da_done)
		else $error("filter done longer than one cycle");
	a_filter_lat: assert property (rx_da_done |-> $past(rx_da_valid, 18) || $past(rx_da_valid, 19))
		else $error("filter done without frame");
	a_full_covers: assert property (full_mac_reset |-> rx_path_reset && tx_path_reset)
		else $error("full reset not on both paths");
	a_tx_rst_len: assert property ($rose(tx_path_reset) |-> tx_path_reset[*8] ##1 tx_path_reset[*8]
		##1 !tx_path_reset)
		else $error("tx reset length wrong");
	a_pad_follows: assert property (rx_header_pad == rx_checksum_offload_off)
		else $error("header pad differs from offload off");
	c_pause: cover property (pause_tx_start);
	c_filter: cover property (rx_da_done);
	c_err: cover property (pslverr);
endmodule

bind gmc_top gmc_sva gmc_sva_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .pause_tx_start(pause_tx_start), .rx_da_valid(rx_da_valid),
	.rx_da_done(rx_da_done), .rx_path_reset(rx_path_reset), .tx_path_reset(tx_path_reset),
	.full_mac_reset(full_mac_reset), .rx_checksum_offload_off(rx_checksum_offload_off),
	.rx_header_pad(rx_header_pad));

// File: gmc_top.v
// control and status slice of a gigabit ethernet mac, apb slave with interrupt
// assumes mac sections honour the reset levels and report pause completion
//
// Notes on behaviour
// - writing 1 to reset bit 13 resets rx sections; reads 1 until done
// - writing 1 to reset bit 15 resets tx sections; reads 0 when done
// - writing 1 to reset bit 31 resets all sections; returns to 0 when done
// - writing 1 to pause request bit 31 starts a pause frame unless one is still pending; 0 does nothing
// - pause request bit clears itself once the pause frame is sent
// - sixteen programmable station address entries filter destination addresses
// - mask bits 23:16 map to address bits 7:0; a 0 excludes that bit
// - frame accepted for a valid entry when all unmasked address bits match
// - rx status bit 31 set while fill level exceeds almost-full threshold
// - rx status bit 30 set while fill level is below almost-empty threshold
// - rx status bit 29 set while fill level is below read threshold
// - tx status bit 31 always reads 0
// - offload bit 2 set disables rx checksum support, clear keeps it
// - while rx checksum is off, padding goes into the mac header
// - pause data register supplies the content of sent pause frames
// - rx flow control register governs handling of received pause frames
// - rx mac enable register controls whether rx mac operates
`include "gmc_regs.vh"
module gmc_top (
	// apb slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// interrupt
	output reg         irq,
	// section resets
	output reg         rx_path_reset,
	output reg         tx_path_reset,
	output reg         full_mac_reset,
	// pause transmit and receive control
	output reg  [31:0] pause_frame_data,
	output reg         pause_tx_start,
	input  wire        pause_tx_done,
	output reg  [31:0] rx_flow_control,
	// destination address filter
	input  wire [47:0] rx_da,
	input  wire        rx_da_valid,
	output reg         rx_da_done,
	output reg         rx_da_accept,
	output reg  [3:0]  rx_da_hit_index,
	// fifo levels
	input  wire [7:0]  rx_fifo_level,
	input  wire [7:0]  tx_fifo_level,
	// receive path control
	output reg         rx_checksum_offload_off,
	output reg         rx_header_pad,
	output reg         rx_mac_enable,
	output reg  [31:0] low_power_idle_control
);

	localparam S_IDLE = 1'b0;
	localparam S_SCAN = 1'b1;

	// bus phase decode
	wire        acc_ph  = psel & penable;
	wire        xfer    = acc_ph & pready;
	wire        wr      = xfer & pwrite;
	wire        in_tab  = (paddr[`GMC_TAB_SEL] == `GMC_TAB_PAGE) && !paddr[`GMC_TAB_GAP] &&
	                      (paddr[`GMC_ALIGN] == 2'b00);
	wire [3:0]  tab_idx = paddr[`GMC_TAB_IDX];
	wire        tab_hi  = paddr[`GMC_TAB_HI_BIT];

	reg  [31:0] rxmode_q;
	reg         pause_req_q;
	reg  [`GMC_IRQ_W-1:0] irq_sts_q;
	reg  [`GMC_IRQ_W-1:0] irq_msk_q;
	reg  [15:0] ent_vld_q;
	reg         rx_af_q;
	reg         rx_ae_q;
	reg         rx_rt_q;
	reg  [31:0] rd_d;
	reg         err_d;

	// filter scan state
	reg         st_q;
	reg  [47:0] da_q;
	reg  [4:0]  idx_q;
	reg         cmp_vld_q;
	reg  [3:0]  cmp_idx_q;
	reg         hit_q;
	reg  [3:0]  hit_idx_q;

	wire [55:0] mem_a;
	wire [55:0] mem_b;
	wire        rx_busy;
	wire        tx_busy;
	wire        all_busy;
	wire        rx_done;
	wire        tx_done;
	wire        all_done;

	// only mask bits of 1 take part in bits 7:0
	function da_match;
		input [47:0] da;
		input [55:0] ent;
		begin
			da_match = ((da ^ ent[47:0]) & {40'hFF_FFFF_FFFF, ent[55:48]}) == 48'h0;
		end
	endfunction

	wire is_rst  = wr && (paddr == `GMC_OFS_RESET);
	wire rx_go   = is_rst & pwdata[`GMC_RST_RX_BIT];
	wire tx_go   = is_rst & pwdata[`GMC_RST_TX_BIT];
	wire all_go  = is_rst & pwdata[`GMC_RST_ALL_BIT];

	gmc_rst_timer u_rx_rst (
		.clk   (pclk),
		.rst_n (presetn),
		.start (rx_go),
		.busy  (rx_busy),
		.done  (rx_done)
	);

	gmc_rst_timer u_tx_rst (
		.clk   (pclk),
		.rst_n (presetn),
		.start (tx_go),
		.busy  (tx_busy),
		.done  (tx_done)
	);

	gmc_rst_timer u_all_rst (
		.clk   (pclk),
		.rst_n (presetn),
		.start (all_go),
		.busy  (all_busy),
		.done  (all_done)
	);

	// sixteen entries, written from the bus, scanned by the filter
	gmc_addr_mem u_tab (
		.clk     (pclk),
		.wr_idx  (tab_idx),
		.we_lo   (wr & in_tab & !tab_hi),
		.we_hi   (wr & in_tab & tab_hi),
		.wdata   (pwdata),
		.ra_idx  (tab_idx),
		.ra_data (mem_a),
		.rb_idx  (idx_q[3:0]),
		.rb_data (mem_b)
	);

	// a written 1 starts a frame unless one is still pending, set wins over completion
	wire pause_set  = wr && (paddr == `GMC_OFS_PAUSE_CTL) && pwdata[`GMC_PAUSE_REQ_BIT] &&
	                  (!pause_req_q || pause_tx_done);
	wire pause_end  = pause_req_q & pause_tx_done;

	// compare stage, entry valid and all unmasked bits equal
	wire this_hit   = cmp_vld_q & ent_vld_q[cmp_idx_q] & da_match(da_q, mem_b);
	wire scan_last  = cmp_vld_q && (cmp_idx_q == `GMC_ENT_LAST);
	wire scan_acc   = hit_q | this_hit;
	wire rx_held    = rx_busy | all_busy;

	// read mux and address decode
	always @* begin
		rd_d  = 32'h0000_0000;
		err_d = 1'b0;
		if (in_tab) begin
			if (tab_hi) begin
				rd_d[23:0]             = mem_a[55:32];
				rd_d[`GMC_ADR_VLD_BIT] = ent_vld_q[tab_idx];
			end else begin
				rd_d = mem_a[31:0];
			end
		end else begin
			case (paddr)
			`GMC_OFS_RESET: begin
				rd_d[`GMC_RST_RX_BIT]  = rx_busy;
				rd_d[`GMC_RST_TX_BIT]  = tx_busy;
				rd_d[`GMC_RST_ALL_BIT] = all_busy;
			end
			`GMC_OFS_PAUSE_CTL: begin
				rd_d[`GMC_PAUSE_REQ_BIT] = pause_req_q;
			end
			`GMC_OFS_PAUSE_DATA: begin
				rd_d = pause_frame_data;
			end
			`GMC_OFS_FLOW: begin
				rd_d = rx_flow_control;
			end
			`GMC_OFS_RXMODE: begin
				rd_d = rxmode_q;
			end
			`GMC_OFS_RXFIFO: begin
				rd_d[`GMC_RXF_AF_BIT] = rx_af_q;
				rd_d[`GMC_RXF_AE_BIT] = rx_ae_q;
				rd_d[`GMC_RXF_RT_BIT] = rx_rt_q;
				rd_d[`GMC_RXF_LVL]    = rx_fifo_level;
			end
			// no full flag, bit stays zero
			`GMC_OFS_TXFIFO: begin
				rd_d[`GMC_TXF_LVL]      = tx_fifo_level;
				rd_d[`GMC_TXF_FULL_BIT] = 1'b0;
			end
			`GMC_OFS_OFFLOAD: begin
				rd_d[`GMC_ACC_RXOFF_BIT] = rx_checksum_offload_off;
			end
			`GMC_OFS_RXMAC_ENA: begin
				rd_d[`GMC_RXENA_BIT] = rx_mac_enable;
			end
			`GMC_OFS_LPI: begin
				rd_d = low_power_idle_control;
			end
			`GMC_OFS_IRQ_STS: begin
				rd_d[`GMC_IRQ_W-1:0] = irq_sts_q;
			end
			`GMC_OFS_IRQ_MSK: begin
				rd_d[`GMC_IRQ_W-1:0] = irq_msk_q;
			end
			default: begin
				err_d = 1'b1;
			end
			endcase
		end
	end

	// one wait state: table read data lands in the first access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc_ph & !pready;
			pslverr <= acc_ph & !pready & err_d;
			if (acc_ph && !pready && !pwrite) begin
				prdata <= err_d ? 32'h0000_0000 : rd_d;
			end
		end
	end

	// software-written control registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_frame_data        <= `GMC_RST_WORD;
			rx_flow_control         <= `GMC_RST_WORD;
			rxmode_q                <= `GMC_RXMODE_RST;
			rx_checksum_offload_off <= 1'b0;
			rx_header_pad           <= 1'b0;
			rx_mac_enable           <= 1'b0;
			low_power_idle_control  <= `GMC_RST_WORD;
			irq_msk_q               <= {`GMC_IRQ_W{1'b0}};
			ent_vld_q               <= 16'h0000;
		end else if (wr) begin
			case (paddr)
			// content handed to the pause transmitter
			`GMC_OFS_PAUSE_DATA: pause_frame_data <= pwdata;
			`GMC_OFS_FLOW: rx_flow_control <= pwdata;
			`GMC_OFS_RXMODE: rxmode_q <= pwdata;
			`GMC_OFS_OFFLOAD: begin
				// 1 turns rx checksum support off
				rx_checksum_offload_off <= pwdata[`GMC_ACC_RXOFF_BIT];
				rx_header_pad           <= pwdata[`GMC_ACC_RXOFF_BIT];
			end
			`GMC_OFS_RXMAC_ENA: rx_mac_enable <= pwdata[`GMC_RXENA_BIT];
			// stored as written; keeping it clear behind the switch is up to software
			`GMC_OFS_LPI: low_power_idle_control <= pwdata;
			`GMC_OFS_IRQ_MSK: irq_msk_q <= pwdata[`GMC_IRQ_W-1:0];
			default: begin
				if (in_tab && tab_hi) begin
					ent_vld_q[tab_idx] <= pwdata[`GMC_ADR_VLD_BIT];
				end
			end
			endcase
		end
	end

	// pause request and section reset outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_req_q    <= 1'b0;
			pause_tx_start <= 1'b0;
			rx_path_reset  <= 1'b0;
			tx_path_reset  <= 1'b0;
			full_mac_reset <= 1'b0;
		end else begin
			pause_tx_start <= pause_set;
			if (pause_set) begin
				pause_req_q <= 1'b1;
			end else if (pause_end || all_busy) begin
				pause_req_q <= 1'b0;
			end
			rx_path_reset  <= rx_held;
			tx_path_reset  <= tx_busy | all_busy;
			full_mac_reset <= all_busy;
		end
	end

	// fifo threshold flags, sampled every cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_af_q <= 1'b0;
			rx_ae_q <= 1'b0;
			rx_rt_q <= 1'b0;
		end else begin
			rx_af_q <= rx_fifo_level > rxmode_q[`GMC_RXM_AF];
			rx_ae_q <= rx_fifo_level < rxmode_q[`GMC_RXM_AE];
			rx_rt_q <= rx_fifo_level < rxmode_q[`GMC_RXM_RT];
		end
	end

	// destination scan; one entry per cycle, a frame takes 18 cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q            <= S_IDLE;
			da_q            <= 48'h0;
			idx_q           <= 5'h00;
			cmp_vld_q       <= 1'b0;
			cmp_idx_q       <= 4'h0;
			hit_q           <= 1'b0;
			hit_idx_q       <= 4'h0;
			rx_da_done      <= 1'b0;
			rx_da_accept    <= 1'b0;
			rx_da_hit_index <= 4'h0;
		end else begin
			rx_da_done <= 1'b0;
			case (st_q)
			S_IDLE: begin
				cmp_vld_q <= 1'b0;
				// receiver off or in reset drops addresses
				if (rx_da_valid && rx_mac_enable && !rx_held) begin
					da_q  <= rx_da;
					idx_q <= 5'h00;
					hit_q <= 1'b0;
					st_q  <= S_SCAN;
				end
			end
			S_SCAN: begin
				if (idx_q != `GMC_SCAN_END) begin
					idx_q     <= idx_q + 5'h01;
					cmp_idx_q <= idx_q[3:0];
					cmp_vld_q <= 1'b1;
				end else begin
					cmp_vld_q <= 1'b0;
				end
				// first matching entry wins
				if (this_hit && !hit_q) begin
					hit_q     <= 1'b1;
					hit_idx_q <= cmp_idx_q;
				end
				if (scan_last) begin
					rx_da_done      <= 1'b1;
					rx_da_accept    <= scan_acc;
					rx_da_hit_index <= hit_q ? hit_idx_q : cmp_idx_q;
					st_q            <= S_IDLE;
				end
				// an rx or full reset aborts the scan with no result, unless it lands in the last compare cycle, where done still pulses
				if (rx_held) begin
					st_q      <= S_IDLE;
					cmp_vld_q <= 1'b0;
				end
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end

	// sticky events, write one to clear; a new event beats the clear
	wire [`GMC_IRQ_W-1:0] irq_ev  = {
		rx_da_done & !rx_da_accept,
		rx_da_done & rx_da_accept,
		all_done,
		tx_done,
		rx_done,
		pause_end
	};
	wire [`GMC_IRQ_W-1:0] irq_clr = (wr && (paddr == `GMC_OFS_IRQ_STS)) ?
	                                pwdata[`GMC_IRQ_W-1:0] : {`GMC_IRQ_W{1'b0}};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_sts_q <= {`GMC_IRQ_W{1'b0}};
			irq       <= 1'b0;
		end else begin
			irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_ev;
			irq       <= |(irq_sts_q & irq_msk_q);
		end
	end

endmodule

// File: gmc_top_bench.sv
// self-checking bench of gmc_top with the pause link model
// assumes gmc_top, gmc_link_model and the bound checker compile first
module gmc_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [47:0] rx_da = 48'h0;
	logic        rx_da_valid = 1'b0;
	logic [7:0]  rx_fifo_level = 8'h00;
	logic [7:0]  tx_fifo_level = 8'h00;
	logic        slow = 1'b0;
	logic [31:0] prdata, pause_frame_data, rx_flow_control, low_power_idle_control, r;
	logic        pready, pslverr, irq, rx_path_reset, tx_path_reset, full_mac_reset, perr;
	logic        pause_tx_start, pause_tx_done, rx_da_done, rx_da_accept;
	logic        rx_checksum_offload_off, rx_header_pad, rx_mac_enable;
	logic [3:0]  rx_da_hit_index;
	logic [7:0]  starts;
	int          mismatches = 0;
	int          total_checks = 0;

	gmc_top gmc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.rx_path_reset(rx_path_reset), .tx_path_reset(tx_path_reset), .full_mac_reset(full_mac_reset),
		.pause_frame_data(pause_frame_data), .pause_tx_start(pause_tx_start),
		.pause_tx_done(pause_tx_done), .rx_flow_control(rx_flow_control), .rx_da(rx_da),
		.rx_da_valid(rx_da_valid), .rx_da_done(rx_da_done), .rx_da_accept(rx_da_accept),
		.rx_da_hit_index(rx_da_hit_index), .rx_fifo_level(rx_fifo_level), .tx_fifo_level(tx_fifo_level),
		.rx_checksum_offload_off(rx_checksum_offload_off), .rx_header_pad(rx_header_pad),
		.rx_mac_enable(rx_mac_enable), .low_power_idle_control(low_power_idle_control));
	gmc_link_model gmc_link_model_i (.clk(pclk), .rst_n(presetn), .pause_tx_start(pause_tx_start),
		.pause_tx_done(pause_tx_done), .slow(slow), .starts(starts));

	initial forever #5 pclk = ~pclk;

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: only the watchdog ends a stalled wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		perr = pslverr;
		chk(1'b1, pready);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(e, r);
	endtask

	task t_regs;
		apb(12'h008, 1'b1, 32'hCAFE_0123);
		chk(32'hCAFE_0123, pause_frame_data);
		apb(12'h00C, 1'b1, 32'h0000_0005);
		chk(32'h0000_0005, rx_flow_control);
		apb(12'h01C, 1'b1, 32'h0000_0004);
		chk(2'b11, {rx_checksum_offload_off, rx_header_pad});
		apb(12'h01C, 1'b1, 32'h0000_0000);
		chk(2'b00, {rx_checksum_offload_off, rx_header_pad});
		apb(12'h800, 1'b1, 32'hFFFF_FFFF);
		chk(1'b1, perr);
		rdc(12'h800, 32'h0000_0000);
		// lpi left unprogrammed: the link partner sits behind the switch
		rdc(12'h024, 32'h0000_0000);
		chk(32'h0000_0000, low_power_idle_control);
	endtask

	task t_resets;
		int b[3] = '{13, 15, 31};
		logic [2:0] o[3] = '{3'b001, 3'b010, 3'b111};
		for (int i = 0; i < 3; i++) begin
			apb(12'h000, 1'b1, 32'h1 << b[i]);
			chk(o[i], {full_mac_reset, tx_path_reset, rx_path_reset});
			rdc(12'h000, 32'h1 << b[i]);
			repeat (16) @(posedge pclk);
			rdc(12'h000, 32'h0);
			chk(3'b000, {full_mac_reset, tx_path_reset, rx_path_reset});
		end
		rdc(12'h028, 32'h0000_000E);
		chk(1'b0, irq);
		apb(12'h02C, 1'b1, 32'h0000_0008);
		chk(1'b1, irq);
		apb(12'h028, 1'b1, 32'h0000_000E);
		chk(1'b0, irq);
		rdc(12'h028, 32'h0000_0000);
		apb(12'h02C, 1'b1, 32'h0);
	endtask

	task t_fifo;
		logic [7:0] lv[4] = '{8'h11, 8'h03, 8'h10, 8'h07};
		logic [2:0] fl[4] = '{3'b100, 3'b011, 3'b000, 3'b001};
		apb(12'h010, 1'b1, 32'h0008_0410);
		for (int i = 0; i < 4; i++) begin
			rx_fifo_level <= lv[i];
			apb(12'h014, 1'b1, 32'hFFFF_FFFF);
			rdc(12'h014, {fl[i], 21'h0, lv[i]});
		end
		tx_fifo_level <= 8'hFF;
		rdc(12'h018, 32'h0000_00FF);
	endtask

	task t_pause;
		apb(12'h004, 1'b1, 32'h0);
		chk(8'h00, starts);
		for (int i = 0; i < 2; i++) begin
			slow <= i[0];
			apb(12'h004, 1'b1, 32'h8000_0000);
			rdc(12'h004, i ? 32'h8000_0000 : 32'h0);
			repeat (30) @(posedge pclk);
			rdc(12'h004, 32'h0);
			chk(i + 1, starts);
		end
		rdc(12'h028, 32'h0000_0001);
	endtask

	task automatic filt(input logic [47:0] d, input logic ea, input logic [3:0] ei);
		int n;
		@(posedge pclk);
		rx_da <= d;
		rx_da_valid <= 1'b1;
		@(posedge pclk);
		rx_da_valid <= 1'b0;
		n = 0;
		while (rx_da_done !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk({ea, 1'b1}, {rx_da_accept, rx_da_done});
		if (ea)
			chk(ei, rx_da_hit_index);
	endtask

	task t_filter;
		logic seen;
		apb(12'h020, 1'b1, 32'h1);
		apb(12'h128, 1'b1, 32'h3344_5566);
		apb(12'h12C, 1'b1, 32'h80F8_1122);
		apb(12'h178, 1'b1, 32'hAABB_CC00);
		apb(12'h17C, 1'b1, 32'h80FF_0102);
		chk(1'b1, rx_mac_enable);
		rdc(12'h128, 32'h3344_5566);
		rdc(12'h12C, 32'h80F8_1122);
		filt(48'h1122_3344_5567, 1'b1, 4'h5);
		filt(48'h1122_3344_556E, 1'b0, 4'h0);
		filt(48'h0102_AABB_CC00, 1'b1, 4'hF);
		filt(48'h0102_AABB_CC01, 1'b0, 4'h0);
		rdc(12'h028, 32'h0000_0031);
		apb(12'h020, 1'b1, 32'h0);
		chk(1'b0, rx_mac_enable);
		rx_da_valid <= 1'b1;
		@(posedge pclk);
		rx_da_valid <= 1'b0;
		seen = 1'b0;
		repeat (24) begin
			@(posedge pclk);
			seen = seen | rx_da_done;
		end
		chk(1'b0, seen);
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_resets;
		t_fifo;
		t_pause;
		t_filter;
		wrap_up;
	end

	initial begin
		#100000;
		mismatches++;
		wrap_up;
	end
endmodule
